// >>> rtl/kbd_mailbox_map.vh
/*
  Port offsets, field positions, reset values and fixed codes of the
  keyboard command mailbox.
  Assumes inclusion by bare name from rtl/ files.
*/
`ifndef KBD_MAILBOX_MAP_VH
`define KBD_MAILBOX_MAP_VH

// ==========================================================
// Port offsets on the host I/O bus
`define PORT_DATA 8'h60
`define PORT_CTRL 8'h64
`define PORT_DRIVER_IN 8'h68
`define PORT_CMD_OUT 8'h69
`define PORT_CMD_CLEAR 8'h6A

// ==========================================================
// Fixed codes and reset values
`define ACK_CODE 8'hFA
`define BYTE_RESET 8'h00

// ==========================================================
// Status bits returned by a read of the controller port
`define STAT_OUT_FULL 0
`define STAT_CMD_WAIT 1
`define STAT_CMD_POSTED 2
`define STAT_LAST_CTRL 3
`define STAT_INHIBIT 4
`define STAT_SCAN_BACKLOG 5

`endif

// >>> rtl/two_entry_buffer.v
/*
  Two-entry buffer with valid/ready on both sides.
  Assumes single clock, asynchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module two_entry_buffer #(
  parameter WIDTH = 8
) (
  input wire clk_sys,
  input wire rst,
  input wire in_valid,
  output reg in_ready_ff,
  input wire [WIDTH-1:0] in_data,
  output reg out_valid_ff,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] slot0_ff;
  reg [WIDTH-1:0] slot1_ff;
  reg wr_ptr_ff;
  reg rd_ptr_ff;
  reg [1:0] count_ff;
  reg [1:0] nxt_count;
  wire push;
  wire pop;

  // ==========================================================
  // Handshakes
  assign push = in_valid & in_ready_ff;
  assign pop = out_valid_ff & out_ready;
  assign out_data = rd_ptr_ff ? slot1_ff : slot0_ff;

  // Occupancy after this cycle
  always @* begin
    nxt_count = count_ff;
    if (push & ~pop) begin
      nxt_count = count_ff + 2'd1;
    end else if (pop & ~push) begin
      nxt_count = count_ff - 2'd1;
    end
  end

  // Storage, pointers and registered flags
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      slot0_ff <= {WIDTH{1'b0}};
      slot1_ff <= {WIDTH{1'b0}};
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff <= 2'd0;
      in_ready_ff <= 1'b1;
      out_valid_ff <= 1'b0;
    end else begin
      if (push) begin
        if (wr_ptr_ff) begin
          slot1_ff <= in_data;
        end else begin
          slot0_ff <= in_data;
        end
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      count_ff <= nxt_count;
      in_ready_ff <= (nxt_count != 2'd2); // Honest full
      out_valid_ff <= (nxt_count != 2'd0); // Honest empty
    end
  end

endmodule // two_entry_buffer

`default_nettype wire

// >>> rtl/keyboard_command_mailbox.v
/*
  Port-mapped keyboard mailbox between host processor and keyboard
  controller: data/status ports, driver input, command-out and clear.
  Assumes host I/O strobes are one-cycle pulses on clk_sys; the keylock
  switch is asynchronous.
*/
// What this block does
// - A scan code from the driver port is loaded into the output buffer, raising its irq.
// - Every command byte is acknowledged by placing FA in the data port.
// - With the ack, or at the freeing clear if command-out is busy, a command goes to command-out unless one already waits, with a low irq pulse latching irq.
// - A clear-port write drops the latched command irq and frees command-out, unless a waiting command is posted in its place.
// - The clear-port write is signalled on the completion-sense output.
// - The controller port takes controller commands on write and returns status on read.
// - While keylock inhibits, responses still return but scan codes are dropped.
`timescale 1ns/1ps
`default_nettype none
`include "kbd_mailbox_map.vh"

module keyboard_command_mailbox #(
  parameter DATA_W = 8
) (
  input wire clk_sys,
  input wire rst,
  input wire [7:0] io_addr,
  input wire io_wr,
  input wire io_rd,
  input wire [DATA_W-1:0] io_wdata,
  output reg [DATA_W-1:0] io_rdata_ff,
  output reg io_rvalid_ff,
  output reg driver_port_ready_ff,
  input wire keylock_inhibit,
  output reg output_buffer_irq_ff,
  output reg link_command_irq_ff,
  output reg command_irq_pulse_n_ff,
  output reg host_done_sense_ff,
  output reg [DATA_W-1:0] ctrl_command_ff,
  output reg ctrl_command_strobe_ff
);

  // ==========================================================
  // Declarations
  reg inhibit_meta_ff;
  reg inhibit_sync_ff;
  reg [DATA_W-1:0] data_port_ff;
  reg [DATA_W-1:0] command_out_ff;
  reg [DATA_W-1:0] cmd_wait_ff;
  reg cmd_wait_valid_ff;
  reg last_ctrl_ff;
  wire wr_data;
  wire wr_ctrl;
  wire wr_driver;
  wire wr_clear;
  wire rd_data;
  wire scan_valid;
  wire scan_ready;
  wire buf_in_ready;
  wire buf_out_valid;
  wire [DATA_W-1:0] buf_out_data;
  wire buf_pop;
  wire post_cmd;
  wire [DATA_W-1:0] post_value;
  wire [DATA_W-1:0] status_byte;

  // Port decode helper
  function hit;
    input [7:0] addr;
    input [7:0] port;
    begin
      hit = (addr == port);
    end
  endfunction

  // ==========================================================
  // Keylock switch synchroniser
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      inhibit_meta_ff <= 1'b0;
      inhibit_sync_ff <= 1'b0;
    end else begin
      inhibit_meta_ff <= keylock_inhibit;
      inhibit_sync_ff <= inhibit_meta_ff;
    end
  end

  // ==========================================================
  // Strobe decode
  assign wr_data = io_wr & hit(io_addr, `PORT_DATA);
  assign wr_ctrl = io_wr & hit(io_addr, `PORT_CTRL);
  assign wr_driver = io_wr & hit(io_addr, `PORT_DRIVER_IN);
  assign wr_clear = io_wr & hit(io_addr, `PORT_CMD_CLEAR);
  assign rd_data = io_rd & hit(io_addr, `PORT_DATA);

  // Scan codes dropped at the door while locked
  assign scan_valid = wr_driver & ~inhibit_sync_ff;

  // ==========================================================
  // Scan code buffer; drains only into an empty output buffer
  two_entry_buffer #(
    .WIDTH(DATA_W)
  ) u_scan_buffer (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(scan_valid),
    .in_ready_ff(buf_in_ready),
    .in_data(io_wdata),
    .out_valid_ff(buf_out_valid),
    .out_ready(scan_ready),
    .out_data(buf_out_data)
  );

  // An ack or a still-unread byte holds the buffer back
  assign scan_ready = ~output_buffer_irq_ff & ~wr_data;
  assign buf_pop = buf_out_valid & scan_ready;

  // Ready toward the driver, registered
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      driver_port_ready_ff <= 1'b0;
    end else begin
      driver_port_ready_ff <= buf_in_ready;
    end
  end

  // ==========================================================
  // Data port and output-buffer interrupt
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      data_port_ff <= `BYTE_RESET;
      output_buffer_irq_ff <= 1'b0;
    end else begin
      if (wr_data) begin
        data_port_ff <= `ACK_CODE;
        output_buffer_irq_ff <= 1'b1;
      end else if (buf_pop) begin
        data_port_ff <= buf_out_data;
        output_buffer_irq_ff <= 1'b1;
      end else if (rd_data) begin
        output_buffer_irq_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Command posting: one byte waits while command-out is occupied
  assign post_cmd = (wr_data | cmd_wait_valid_ff) & (~link_command_irq_ff | wr_clear) &
    ~(wr_data & cmd_wait_valid_ff);
  assign post_value = cmd_wait_valid_ff ? cmd_wait_ff : io_wdata;

  // Waiting command slot
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmd_wait_ff <= `BYTE_RESET;
      cmd_wait_valid_ff <= 1'b0;
    end else begin
      if (post_cmd & cmd_wait_valid_ff) begin
        cmd_wait_valid_ff <= 1'b0;
      end else if (wr_data & ~post_cmd & ~cmd_wait_valid_ff) begin
        cmd_wait_ff <= io_wdata;
        cmd_wait_valid_ff <= 1'b1;
      end
    end
  end

  // Command-out port, pulse and latched interrupt
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      command_out_ff <= `BYTE_RESET;
      command_irq_pulse_n_ff <= 1'b1;
      link_command_irq_ff <= 1'b0;
      host_done_sense_ff <= 1'b0;
    end else begin
      command_irq_pulse_n_ff <= ~post_cmd;
      host_done_sense_ff <= wr_clear;
      if (post_cmd) begin
        command_out_ff <= post_value;
        link_command_irq_ff <= 1'b1;
      end else if (wr_clear) begin
        link_command_irq_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Controller command port
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_command_ff <= `BYTE_RESET;
      ctrl_command_strobe_ff <= 1'b0;
      last_ctrl_ff <= 1'b0;
    end else begin
      ctrl_command_strobe_ff <= wr_ctrl;
      if (wr_ctrl) begin
        ctrl_command_ff <= io_wdata;
        last_ctrl_ff <= 1'b1;
      end else if (wr_data) begin
        last_ctrl_ff <= 1'b0;
      end
    end
  end

  // Status byte of the controller port
  assign status_byte = {{(DATA_W-6){1'b0}},
    buf_out_valid,
    inhibit_sync_ff,
    last_ctrl_ff,
    link_command_irq_ff,
    cmd_wait_valid_ff,
    output_buffer_irq_ff};

  // ==========================================================
  // Read data, one cycle after the strobe
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      io_rdata_ff <= `BYTE_RESET;
      io_rvalid_ff <= 1'b0;
    end else begin
      io_rvalid_ff <= io_rd;
      if (io_rd) begin
        case (io_addr)
          `PORT_DATA: io_rdata_ff <= data_port_ff;
          `PORT_CTRL: io_rdata_ff <= status_byte;
          `PORT_CMD_OUT: io_rdata_ff <= command_out_ff;
          default: io_rdata_ff <= `BYTE_RESET;
        endcase
      end
    end
  end

endmodule // keyboard_command_mailbox

`default_nettype wire

// >>> verification/mailbox_checker_asserts.sv
/*
  Port assertions for the keyboard command mailbox.
  Assumes one clock, async active-high reset, bound to the top module.
*/
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port checker
module mailbox_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata_ff,
  input wire logic io_rvalid_ff,
  input wire logic driver_port_ready_ff,
  input wire logic keylock_inhibit,
  input wire logic output_buffer_irq_ff,
  input wire logic link_command_irq_ff,
  input wire logic command_irq_pulse_n_ff,
  input wire logic host_done_sense_ff,
  input wire logic [7:0] ctrl_command_ff,
  input wire logic ctrl_command_strobe_ff
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // Accepted scan write with keylock settled low
  sequence scan_s;
    (!keylock_inhibit)[*3] ##0 (io_wr && io_addr == 8'h68 && driver_port_ready_ff);
  endsequence
  // Low pulse then release
  sequence pulse_s;
    link_command_irq_ff ##1 command_irq_pulse_n_ff;
  endsequence
  scan_load_a:
    assert property (scan_s |-> ##[1:40] output_buffer_irq_ff) else $error("scan not loaded");
  cmd_ack_a:
    assert property (io_wr && io_addr == 8'h60 |=> output_buffer_irq_ff) else $error("no ack");
  cmd_post_a:
    assert property (io_wr && io_addr == 8'h60 && !link_command_irq_ff
      |=> !command_irq_pulse_n_ff && link_command_irq_ff) else $error("command not posted");
  pulse_shape_a:
    assert property ($fell(command_irq_pulse_n_ff) |-> pulse_s) else $error("bad irq pulse");
  post_hold_a:
    assert property (link_command_irq_ff && !(io_wr && io_addr == 8'h6A)
      |=> link_command_irq_ff && command_irq_pulse_n_ff) else $error("command overwritten");
  done_sense_a:
    assert property (io_wr && io_addr == 8'h6A |=> host_done_sense_ff) else $error("no sense");
  ctrl_cmd_a:
    assert property (io_wr && io_addr == 8'h64 |=> ctrl_command_strobe_ff
      && ctrl_command_ff == $past(io_wdata)) else $error("ctrl command lost");
  ctrl_stat_a:
    assert property (io_rd && io_addr == 8'h64 |=> io_rvalid_ff && io_rdata_ff[7:6] == 2'h0)
      else $error("bad status read");
  reset_idle_a:
    assert property ($fell(rst) |-> !output_buffer_irq_ff && !link_command_irq_ff
      && command_irq_pulse_n_ff) else $error("not idle after reset");
endmodule // mailbox_checker

bind keyboard_command_mailbox mailbox_checker mailbox_checker_i (.clk_sys, .rst, .io_addr,
  .io_wr, .io_rd, .io_wdata, .io_rdata_ff, .io_rvalid_ff, .driver_port_ready_ff,
  .keylock_inhibit, .output_buffer_irq_ff, .link_command_irq_ff, .command_irq_pulse_n_ff,
  .host_done_sense_ff, .ctrl_command_ff, .ctrl_command_strobe_ff);
`default_nettype wire

// >>> verification/host_bus.sv
/*
  Host processor model: drives I/O port cycles into the mailbox.
  Assumes falling-edge drive, one-cycle strobes.
*/
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Host I/O master
module host_bus (
  input wire logic clk_sys,
  input wire logic [7:0] io_rdata_ff,
  input wire logic io_rvalid_ff,
  output logic [7:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata
);
  // Idle bus at time zero
  initial begin
    io_addr = 8'h00;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end
  // Port write; released lines show inverted value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clk_sys);
    io_wr = 1'b0;
    io_addr = ~a;
    io_wdata = ~d;
  endtask
  // Port read; answer stands one cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(negedge clk_sys);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clk_sys);
    io_rd = 1'b0;
    io_addr = ~a;
    ok = io_rvalid_ff;
    d = io_rdata_ff;
  endtask
endmodule // host_bus
`default_nettype wire

// >>> verification/keyboard_command_mailbox_tb.sv
/*
  Self-checking bench for the keyboard command mailbox.
  Assumes host_bus model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Bench top
module keyboard_command_mailbox_tb;
  logic clk_sys = 1'b0;
  logic rst;
  logic keylock_inhibit;
  logic [7:0] io_addr, io_wdata, io_rdata_ff, ctrl_command_ff;
  logic io_wr, io_rd, io_rvalid_ff, driver_port_ready_ff, output_buffer_irq_ff;
  logic link_command_irq_ff, command_irq_pulse_n_ff, host_done_sense_ff, ctrl_command_strobe_ff;
  integer failures = 0;
  integer total_checks = 0;
  // 200 MHz clock
  always #2.5 clk_sys = ~clk_sys;
  keyboard_command_mailbox keyboard_command_mailbox_i (.clk_sys, .rst, .io_addr, .io_wr,
    .io_rd, .io_wdata, .io_rdata_ff, .io_rvalid_ff, .driver_port_ready_ff, .keylock_inhibit,
    .output_buffer_irq_ff, .link_command_irq_ff, .command_irq_pulse_n_ff, .host_done_sense_ff,
    .ctrl_command_ff, .ctrl_command_strobe_ff);
  host_bus host_bus_i (.clk_sys, .io_rdata_ff, .io_rvalid_ff, .io_addr, .io_wr, .io_rd,
    .io_wdata);
  // Verdict and end of run
  task automatic final_report;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Compare seen against expected
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // Read a port and compare, valid flag included
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host_bus_i.rd(a, d, ok);
    chk({7'h00, ok}, 8'h01);
    chk(d, exp);
  endtask
  // Bounded wait for the output-buffer irq
  task automatic wait_obf;
    for (int n = 0; n < 8 && output_buffer_irq_ff !== 1'b1; n++)
      @(negedge clk_sys);
    if (output_buffer_irq_ff !== 1'b1) begin
      failures++;
      $display("unexpected %0t obf wait ran out", $time);
      final_report;
    end
  endtask
  // Scan path: latency, fill until refused, drain in order
  task automatic t_scan;
    host_bus_i.wr(8'h68, 8'h11);
    chk({7'h00, output_buffer_irq_ff}, 8'h00);
    @(negedge clk_sys);
    chk({7'h00, output_buffer_irq_ff}, 8'h01);
    host_bus_i.wr(8'h68, 8'h22);
    host_bus_i.wr(8'h68, 8'h33);
    @(negedge clk_sys);
    chk({7'h00, driver_port_ready_ff}, 8'h00);
    rdc(8'h60, 8'h11);
    wait_obf;
    rdc(8'h60, 8'h22);
    wait_obf;
    rdc(8'h60, 8'h33);
    chk({6'h00, output_buffer_irq_ff, driver_port_ready_ff}, 8'h01);
    $display("scan test done");
  endtask
  // Command ack, post, hold while pending, clear
  task automatic t_cmd;
    host_bus_i.wr(8'h60, 8'hED);
    chk({5'h00, command_irq_pulse_n_ff, link_command_irq_ff, output_buffer_irq_ff}, 8'h03);
    rdc(8'h60, 8'hFA);
    rdc(8'h69, 8'hED);
    host_bus_i.wr(8'h69, 8'h55);
    host_bus_i.wr(8'h60, 8'h07);
    chk({6'h00, command_irq_pulse_n_ff, link_command_irq_ff}, 8'h03);
    rdc(8'h69, 8'hED);
    host_bus_i.wr(8'h6A, 8'h00);
    chk({5'h00, host_done_sense_ff, command_irq_pulse_n_ff, link_command_irq_ff}, 8'h05);
    rdc(8'h69, 8'h07);
    host_bus_i.wr(8'h6A, 8'h00);
    chk({5'h00, host_done_sense_ff, command_irq_pulse_n_ff, link_command_irq_ff}, 8'h06);
    rdc(8'h70, 8'h00);
    $display("command test done");
  endtask
  // Controller port write and status
  task automatic t_ctrl;
    host_bus_i.wr(8'h64, 8'hAA);
    chk(ctrl_command_ff, 8'hAA);
    chk({7'h00, ctrl_command_strobe_ff}, 8'h01);
    rdc(8'h64, 8'h09);
    $display("control test done");
  endtask
  // Keylock drops scans, keeps responses
  task automatic t_lock;
    rdc(8'h60, 8'hFA);
    keylock_inhibit = 1'b1;
    repeat (3) @(negedge clk_sys);
    host_bus_i.wr(8'h68, 8'h5A);
    repeat (3) @(negedge clk_sys);
    chk({7'h00, output_buffer_irq_ff}, 8'h00);
    host_bus_i.wr(8'h60, 8'hF4);
    rdc(8'h60, 8'hFA);
    rdc(8'h64, 8'h14);
    host_bus_i.wr(8'h6A, 8'h00);
    keylock_inhibit = 1'b0;
    $display("keylock test done");
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    keylock_inhibit = 1'b0;
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    chk({4'h0, output_buffer_irq_ff, link_command_irq_ff, command_irq_pulse_n_ff,
      driver_port_ready_ff}, 8'h03);
    t_scan;
    t_cmd;
    t_ctrl;
    t_lock;
    final_report;
  end
endmodule // keyboard_command_mailbox_tb
`default_nettype wire
